// ==== design/tfa_regs.v ====
// Configuration register bank: alert masks, beta and series resistance settings, high limits, fan drive.
// Assumes a serial bus front end gives one-cycle write and read strobes with a byte address, on clk.
`timescale 1ns/1ps
`include "tfa_defs.vh"

module tfa_regs (
    input wire clk,
    input wire reset,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    input wire sw_lock,
    input wire [1:0] hw_trip_channel_select,
    input wire auto_fan_en,
    input wire [7:0] auto_drive_level,
    input wire [23:0] diode_temps,
    input wire [2:0] diode_fault_flags,
    input wire [2:0] limit_shutdown_en,
    input wire fan_spin_fail,
    input wire fan_stall,
    input wire other_alert_flags,
    output wire [2:0] diode_over_limit_flags,
    output wire [2:0] beta_comp_en,
    output wire [2:0] diode1_gain_code,
    output wire [2:0] diode2_gain_code,
    output wire [2:0] diode3_gain_code,
    output wire [2:0] series_r_correct_en,
    output wire [7:0] fan_drive_out,
    output wire alert_n,
    output wire system_off_n
);

    // ----------------------------------------------------------------
    // Helpers.
    // ----------------------------------------------------------------
    function over_limit;
        input [7:0] temp;
        input [7:0] lim;
        begin
            over_limit = $signed(temp) > $signed(lim);
        end
    endfunction

    reg [4:0] mask_reg;
    reg [2:0] beta1_reg;
    reg [2:0] beta2_reg;
    reg [2:0] rec_reg;
    reg [7:0] lim1_reg;
    reg [7:0] lim2_reg;
    reg [7:0] lim3_reg;
    reg [7:0] drive_written_reg;
    reg [7:0] drive_applied_reg;
    reg [1:0] sel_s1_reg;
    reg [1:0] sel_s2_reg;
    reg [7:0] rd_next;

    wire sel_d1 = sel_s2_reg == `TFA_SEL_D1;
    wire sel_d3 = sel_s2_reg == `TFA_SEL_D3;
    wire wr_ok = wr_en && !sw_lock;

    // ----------------------------------------------------------------
    // Register writes.
    // ----------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_reg <= `TFA_RST_MASK;
            beta1_reg <= `TFA_RST_BETA;
            beta2_reg <= `TFA_RST_BETA;
            rec_reg <= `TFA_RST_REC;
            lim1_reg <= `TFA_RST_LIM;
            lim2_reg <= `TFA_RST_LIM;
            lim3_reg <= `TFA_RST_LIM;
            drive_written_reg <= `TFA_RST_DRIVE;
            sel_s1_reg <= `TFA_SEL_RST;
            sel_s2_reg <= `TFA_SEL_RST;
        end else begin
            sel_s1_reg <= hw_trip_channel_select;
            sel_s2_reg <= sel_s1_reg;
            if (wr_en && addr == `TFA_ADDR_MASK) begin
                mask_reg <= wr_data[4:0];
            end
            if (wr_ok && addr == `TFA_ADDR_BETA1 && !sel_d1) begin
                beta1_reg <= wr_data[2:0];
            end
            if (wr_ok && addr == `TFA_ADDR_BETA2) begin
                beta2_reg <= wr_data[2:0];
            end
            if (wr_ok && addr == `TFA_ADDR_REC) begin
                rec_reg[0] <= sel_d1 ? rec_reg[0] : wr_data[0];
                rec_reg[1] <= wr_data[1];
                rec_reg[2] <= sel_d3 ? rec_reg[2] : wr_data[2];
            end
            if (wr_ok && addr == `TFA_ADDR_LIM1) begin
                lim1_reg <= wr_data;
            end
            if (wr_ok && addr == `TFA_ADDR_LIM2) begin
                lim2_reg <= wr_data;
            end
            if (wr_ok && addr == `TFA_ADDR_LIM3) begin
                lim3_reg <= wr_data;
            end
            if (wr_en && addr == `TFA_ADDR_DRIVE) begin
                drive_written_reg <= wr_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Applied fan drive.
    // ----------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            drive_applied_reg <= `TFA_RST_DRIVE;
        end else if (auto_fan_en) begin
            drive_applied_reg <= auto_drive_level;
        end else if (wr_en && addr == `TFA_ADDR_DRIVE) begin
            drive_applied_reg <= wr_data;
        end else begin
            drive_applied_reg <= drive_written_reg;
        end
    end

    assign fan_drive_out = drive_applied_reg;

    // ----------------------------------------------------------------
    // Register reads.
    // ----------------------------------------------------------------
    always @* begin
        rd_next = 8'h00;
        case (addr)
            `TFA_ADDR_MASK: rd_next = {3'h0, mask_reg};
            `TFA_ADDR_BETA1: rd_next = sel_d1 ? `TFA_BETA1_TRIP_READ : {5'h00, beta1_reg};
            `TFA_ADDR_BETA2: rd_next = {5'h00, beta2_reg};
            `TFA_ADDR_REC: rd_next = {5'h00, rec_reg};
            `TFA_ADDR_LIM1: rd_next = lim1_reg;
            `TFA_ADDR_LIM2: rd_next = lim2_reg;
            `TFA_ADDR_LIM3: rd_next = lim3_reg;
            `TFA_ADDR_DRIVE: rd_next = drive_applied_reg;
            default: rd_next = 8'h00;
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // Beta, limits, alert and shutdown.
    // ----------------------------------------------------------------
    wire [2:0] beta1_eff = sel_d1 ? `TFA_BETA1_TRIP_CODE : beta1_reg;
    assign diode1_gain_code = beta1_eff;
    assign diode2_gain_code = beta2_reg;
    assign diode3_gain_code = `TFA_BETA_OFF;
    assign beta_comp_en = {1'b0, diode2_gain_code != `TFA_BETA_OFF, diode1_gain_code != `TFA_BETA_OFF};
    assign series_r_correct_en = rec_reg;

    assign diode_over_limit_flags = {over_limit(diode_temps[23:16], lim3_reg),
                                     over_limit(diode_temps[15:8], lim2_reg),
                                     over_limit(diode_temps[7:0], lim1_reg)};

    wire [2:0] chan_flags = diode_over_limit_flags | diode_fault_flags;
    wire alert_any = |(chan_flags & ~mask_reg[2:0])
        | (fan_spin_fail & ~mask_reg[`TFA_MASK_SPIN])
        | (fan_stall & ~mask_reg[`TFA_MASK_STALL])
        | other_alert_flags;
    assign alert_n = ~alert_any;
    assign system_off_n = ~|(diode_over_limit_flags & limit_shutdown_en);

endmodule // tfa_regs

// ==== include/tfa_defs.vh ====
// Register offsets, field positions and reset values of the configuration bank.
// Assumes inclusion by the bank's single design file.
`ifndef TFA_DEFS_VH
`define TFA_DEFS_VH
`define TFA_ADDR_MASK 8'h24
`define TFA_ADDR_BETA1 8'h30
`define TFA_ADDR_BETA2 8'h31
`define TFA_ADDR_REC 8'h32
`define TFA_ADDR_LIM1 8'h41
`define TFA_ADDR_LIM2 8'h42
`define TFA_ADDR_LIM3 8'h43
`define TFA_ADDR_DRIVE 8'h51
`define TFA_RST_MASK 5'h10
`define TFA_RST_BETA 3'h3
`define TFA_RST_REC 3'h7
`define TFA_RST_LIM 8'h55
`define TFA_RST_DRIVE 8'h00
`define TFA_BETA_OFF 3'h7
`define TFA_BETA1_TRIP_READ 8'h05
`define TFA_BETA1_TRIP_CODE 3'h5
`define TFA_SEL_RST 2'h0
`define TFA_MASK_SPIN 4
`define TFA_MASK_STALL 3
`define TFA_SEL_NONE 2'h0
`define TFA_SEL_D1 2'h1
`define TFA_SEL_D3 2'h2
`endif

// ==== tb/testbench.sv ====
// Self-checking bench of the configuration bank.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, reset = 1'b1, sw_lock = 1'b0, auto_fan_en = 1'b0, fan_spin_fail = 1'b0, fan_stall = 1'b0;
    logic wr_en, rd_en, alert_n, system_off_n;
    logic [1:0] hw_trip_channel_select = 2'h0;
    logic [2:0] diode_fault_flags = 3'h0, limit_shutdown_en = 3'h0, diode_over_limit_flags, rec_en;
    logic [7:0] auto_drive_level = 8'h33, addr, wr_data, rd_data, fan_drive_out, got;
    logic [23:0] diode_temps = 24'h000000;
    int err_count = 0, compares = 0;
    logic [31:0] rows [0:14] = '{32'h00240010, 32'h00300003, 32'h00310003, 32'h00320007, 32'h00410055,
        32'h00420055, 32'h00430055, 32'h00510000, 32'h00600000, 32'h0124FF1F, 32'h01310404,
        32'h0130FF07, 32'h0132FA02, 32'h01417F7F, 32'h01518080};
    tfa_host_model host (.clk, .rd_data, .wr_en, .rd_en, .addr, .wr_data);
    tfa_regs dut (.clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .sw_lock, .hw_trip_channel_select,
        .auto_fan_en, .auto_drive_level, .diode_temps, .diode_fault_flags, .limit_shutdown_en, .fan_spin_fail,
        .fan_stall, .other_alert_flags(1'b0), .diode_over_limit_flags, .beta_comp_en(), .diode1_gain_code(),
        .diode2_gain_code(), .diode3_gain_code(), .series_r_correct_en(rec_en), .fan_drive_out, .alert_n,
        .system_off_n);
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, got);
        chk(got, e);
    endtask
    task automatic close_out;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i][24]) host.wr(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], rows[i][7:0]);
        end
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            {fan_spin_fail, fan_stall, diode_fault_flags} <= 5'h01 << i;
            host.wr(8'h24, 8'h01 << i);
            #1 chk(alert_n, 1'b1);
            host.wr(8'h24, 8'h00);
            #1 chk(alert_n, 1'b0);
        end
        @(posedge clk);
        {fan_spin_fail, fan_stall, diode_fault_flags} <= 5'h00;
        diode_temps <= 24'h555680;
        limit_shutdown_en <= 3'h2;
        @(posedge clk);
        #1 chk(diode_over_limit_flags, 3'h2);
        chk(system_off_n, 1'b0);
        @(posedge clk);
        limit_shutdown_en <= 3'h5;
        hw_trip_channel_select <= 2'h1;
        repeat (3) @(posedge clk);
        #1 chk(system_off_n, 1'b1);
        rc(8'h30, 8'h05);
        host.wr(8'h30, 8'h00);
        host.wr(8'h32, 8'h07);
        rc(8'h32, 8'h06);
        chk(rec_en, 3'h6);
        @(posedge clk);
        hw_trip_channel_select <= 2'h0;
        auto_fan_en <= 1'b1;
        repeat (3) @(posedge clk);
        rc(8'h30, 8'h07);
        host.wr(8'h51, 8'hC0);
        rc(8'h51, 8'h33);
        @(posedge clk);
        auto_fan_en <= 1'b0;
        sw_lock <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(fan_drive_out, 8'hC0);
        host.wr(8'h42, 8'h00);
        host.wr(8'h31, 8'h00);
        rc(8'h42, 8'h55);
        rc(8'h31, 8'h04);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        sw_lock <= 1'b0;
        rc(8'h24, 8'h10);
        rc(8'h42, 8'h55);
        rc(8'h51, 8'h00);
        close_out;
    end
endmodule // testbench
bind tfa_regs tfa_regs_asserts u_chk (.*);

// ==== tb/tfa_host_model.sv ====
// Host model: single byte register writes and reads with one-cycle strobes.
// Assumes reads answer on the same edge that takes the strobe.
`timescale 1ns/1ps
module tfa_host_model (
    input logic clk,
    input logic [7:0] rd_data,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data
);
    initial {wr_en, rd_en, addr, wr_data} = 18'h00000;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
endmodule // tfa_host_model

// ==== tb/tfa_regs_asserts.sv ====
// Checker of the configuration bank, seeing its ports only.
// Assumes a bind in the bench top file.
`timescale 1ns/1ps
module tfa_regs_asserts (
    input logic clk, reset, wr_en, rd_en, auto_fan_en, fan_spin_fail, fan_stall,
    input logic other_alert_flags, alert_n, system_off_n,
    input logic [7:0] addr, wr_data, rd_data, fan_drive_out,
    input logic [1:0] hw_trip_channel_select,
    input logic [2:0] diode_fault_flags, limit_shutdown_en, diode_over_limit_flags, beta_comp_en,
    input logic [2:0] diode1_gain_code, diode2_gain_code, diode3_gain_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    alert_idle_a: assert property (!(|{diode_fault_flags, diode_over_limit_flags, fan_spin_fail,
        fan_stall, other_alert_flags}) |-> alert_n) else $error("alert low without flag");
    trip_out_a: assert property (system_off_n == !(|(limit_shutdown_en & diode_over_limit_flags)))
        else $error("system off mismatch");
    comp_en_a: assert property (beta_comp_en == {diode3_gain_code != 3'h7,
        diode2_gain_code != 3'h7, diode1_gain_code != 3'h7}) else $error("compensation enable mismatch");
    d3_fixed_a: assert property (diode3_gain_code == 3'h7) else $error("diode 3 code not fixed");
    trip_beta_a: assert property (hw_trip_channel_select == 2'h1 [*3] |-> diode1_gain_code == 3'h5)
        else $error("diode 1 code not forced");
    manual_drive_a: assert property (wr_en && addr == 8'h51 && !auto_fan_en ##1 !auto_fan_en
        |-> fan_drive_out == $past(wr_data)) else $error("manual drive not applied");
    spare_bits_a: assert property (rd_en && addr inside {8'h30, 8'h31, 8'h32} |=> rd_data[7:3] == 5'h00)
        else $error("spare bits set");
    mask_bits_a: assert property (rd_en && addr == 8'h24 |=> rd_data[7:5] == 3'h0)
        else $error("mask spare bits set");
    cover property (!alert_n);
    cover property (!system_off_n);
    cover property (wr_en && auto_fan_en && addr == 8'h51);
endmodule // tfa_regs_asserts
